/* obd_cfg.svh */
// Constants for the option bit decoder: option byte layout, register map, reset values
// Operation
// - With the watchdog action bit at 0, a watchdog time-out raises an interrupt request.
// - With the watchdog action bit at 1, a time-out forces a short reset; erased value is 1.
// - With always-on at 0 the watchdog runs from power-up and stops only in STOP if set to.
// - With always-on at 1 the watchdog starts on its start instruction; reset or recovery stop it.
// - Oscillator drive 00 is RC below 4 MHz, 01 low-power crystal, 10 medium-power crystal.
// - Oscillator drive 11 is maximum-power crystal drive up to 20 MHz; it is the erased value.
// - Brownout always-on at 0 turns brownout off in STOP; at 1, the erased value, it stays on.
// - Read protect at 0 hides user code and leaves the debug path with limited control only.
// - Option bits come from program memory byte zero and no system reset changes them.
`ifndef OBD_CFG_SVH
`define OBD_CFG_SVH

`define OBD_OPT_ADDR       16'h0000
`define OBD_OPT_ERASED     8'hFF
`define OBD_BIT_WDT_ACT    7
`define OBD_BIT_WDT_SOFT   6
`define OBD_BIT_OSC_HI     5
`define OBD_BIT_OSC_LO     4
`define OBD_BIT_RD_OPEN    3
`define OBD_BIT_BO_AO      2

`define OBD_ADDR_OPTION    12'h000
`define OBD_ADDR_STATE     12'h004
`define OBD_ADDR_CTRL      12'h008
`define OBD_ADDR_IRQ_STAT  12'h00C
`define OBD_ADDR_IRQ_MASK  12'h010

`define OBD_CTRL_RELOAD    0
`define OBD_IRQ_LOADED     0
`define OBD_IRQ_WDT_INT    1
`define OBD_IRQ_WDT_RST    2
`define OBD_IRQ_MASK_RST   3'h0

`endif

/* obd_loader.sv */
// Fetches the option byte from program memory after reset and on request
`include "obd_cfg.svh"
`default_nettype none

module obd_loader
(
  input  wire logic        clk,         // System clock
  input  wire logic        arst_n,      // Asynchronous reset, active low
  input  wire logic        ce,          // Clock enable
  input  wire logic        start,       // Reload request pulse
  output logic             flash_req,   // Read request to program memory
  output logic [15:0]      flash_addr,  // Read address
  input  wire logic [7:0]  flash_rdata, // Read data, valid with ack
  input  wire logic        flash_ack,   // Read done
  output var  logic [7:0]  opt_byte,    // Held option byte
  output var  logic        opt_load,    // One-cycle pulse when byte taken
  output logic             busy         // Read in progress
);

  obd_pkg::obd_ld_state_t state;

  assign flash_req  = (state == obd_pkg::LD_READ);
  assign busy       = (state == obd_pkg::LD_READ);
  assign flash_addr = `OBD_OPT_ADDR;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= obd_pkg::LD_READ;
      opt_byte <= `OBD_OPT_ERASED;
      opt_load <= 1'b0;
    end
    else if (ce)
    begin
      opt_load <= 1'b0;
      unique case (state)
        obd_pkg::LD_READ:
        begin
          if (flash_ack)
          begin
            opt_byte <= flash_rdata;
            opt_load <= 1'b1;
            state    <= obd_pkg::LD_IDLE;
          end
        end
        obd_pkg::LD_IDLE:
        begin
          if (start)
            state <= obd_pkg::LD_READ;
        end
      endcase
    end
  end

endmodule : obd_loader

`default_nettype wire

/* obd_option_decoder.sv */
// Option bit decoder top: loads the option byte, decodes it and serves APB registers
`include "obd_cfg.svh"
`default_nettype none

module obd_option_decoder
(
  input  wire logic        CLK,             // System clock, 10 MHz
  input  wire logic        ARST_N,          // Asynchronous reset, active low
  input  wire logic        CE,              // Clock enable, freezes all state when low
  input  wire logic        PSEL,            // APB select
  input  wire logic        PENABLE,         // APB enable
  input  wire logic        PWRITE,          // APB direction
  input  wire logic [11:0] PADDR,           // APB byte address
  input  wire logic [31:0] PWDATA,          // APB write data
  output var  logic [31:0] PRDATA,          // APB read data
  output logic             PREADY,          // APB ready
  output logic             PSLVERR,         // APB error on unmapped address
  output logic             IRQ,             // Level interrupt
  output logic             FLASH_REQ,       // Program memory read request
  output logic [15:0]      FLASH_ADDR,      // Program memory address
  input  wire logic [7:0]  FLASH_RDATA,     // Program memory data
  input  wire logic        FLASH_ACK,       // Program memory read done
  input  wire logic        SYS_RESET,       // System reset pulse
  input  wire logic        STOP_MODE,       // Device in STOP mode
  input  wire logic        STOP_RECOVERY,   // STOP mode recovery pulse
  input  wire logic        WDT_STOP_PD,     // Watchdog powers down in STOP
  input  wire logic        WDT_START_INSTR, // Watchdog start instruction executed
  input  wire logic        WDT_TIMEOUT,     // Watchdog time-out pulse
  input  wire logic        DEBUG_ATTACH,    // Debug path active, asynchronous pin
  output logic             OPT_READY,       // Option byte has been loaded
  output var  logic        WDT_RUN,         // Watchdog enabled
  output var  logic        WDT_INT_REQ,     // Watchdog interrupt request pulse
  output var  logic        WDT_SHORT_RST,   // Watchdog short reset pulse
  output var  logic [1:0]  OSC_MODE,        // Oscillator drive select
  output var  logic        OSC_RC_EN,       // RC oscillator mode
  output var  logic        OSC_XTAL_LOW,    // Minimum-power crystal drive
  output var  logic        OSC_XTAL_MED,    // Medium-power crystal drive
  output var  logic        OSC_XTAL_HIGH,   // Maximum-power crystal drive
  output var  logic        BROWNOUT_EN,     // Brownout protection active
  output var  logic        CODE_READ_EN,    // User code readable
  output var  logic        DEBUG_FULL,      // Debug path has full control
  output var  logic        DEBUG_LIMITED    // Debug path has limited control
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [3:0] osc_drive(input logic [1:0] sel);
    logic [3:0] hot;
    hot = 4'h0;
    unique case (obd_pkg::obd_osc_mode_t'(sel))
      obd_pkg::OBD_OSC_RC:       hot = 4'h1;
      obd_pkg::OBD_OSC_XTAL_LOW: hot = 4'h2;
      obd_pkg::OBD_OSC_XTAL_MED: hot = 4'h4;
      obd_pkg::OBD_OSC_XTAL_HI:  hot = 4'h8;
    endcase
    return hot;
  endfunction : osc_drive

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
    return (a == reg_addr);
  endfunction : addr_is

  ////////////////////////////////////////////////////////////////////////////////
  // Option byte loading

  logic [7:0]  opt;
  logic        opt_load;
  logic        opt_loaded;
  logic        ld_busy;
  logic        reload;
  logic        dbg_sync;

  obd_loader u_loader
  (
    .clk         (CLK),
    .arst_n      (ARST_N),
    .ce          (CE),
    .start       (reload),
    .flash_req   (FLASH_REQ),
    .flash_addr  (FLASH_ADDR),
    .flash_rdata (FLASH_RDATA),
    .flash_ack   (FLASH_ACK),
    .opt_byte    (opt),
    .opt_load    (opt_load),
    .busy        (ld_busy)
  );

  obd_sync u_dbg_sync
  (
    .clk    (CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .d      (DEBUG_ATTACH),
    .q      (dbg_sync)
  );

  // SYS_RESET deliberately does not touch the loaded byte
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      opt_loaded <= 1'b0;
    else if (CE && opt_load)
      opt_loaded <= 1'b1;
  end

  assign OPT_READY = opt_loaded;

  logic wdt_act;
  logic wdt_soft;
  logic bo_ao;
  logic rd_open;

  assign wdt_act  = opt[`OBD_BIT_WDT_ACT];
  assign wdt_soft = opt[`OBD_BIT_WDT_SOFT];
  assign bo_ao    = opt[`OBD_BIT_BO_AO];
  assign rd_open  = opt[`OBD_BIT_RD_OPEN];

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog enable and time-out action

  logic next_wdt_run;

  always_comb
  begin
    if (!opt_loaded)
      next_wdt_run = 1'b0;
    else if (!wdt_soft)
      next_wdt_run = !(STOP_MODE && WDT_STOP_PD);
    else if (SYS_RESET || STOP_RECOVERY)
      next_wdt_run = 1'b0;
    else if (WDT_START_INSTR)
      next_wdt_run = 1'b1;
    else
      next_wdt_run = WDT_RUN;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      WDT_RUN       <= 1'b0;
      WDT_INT_REQ   <= 1'b0;
      WDT_SHORT_RST <= 1'b0;
    end
    else if (CE)
    begin
      WDT_RUN       <= next_wdt_run;
      WDT_INT_REQ   <= WDT_TIMEOUT && WDT_RUN && !wdt_act;
      WDT_SHORT_RST <= WDT_TIMEOUT && WDT_RUN && wdt_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator, brownout and protection outputs

  logic [3:0] next_osc;

  assign next_osc = osc_drive(opt[`OBD_BIT_OSC_HI:`OBD_BIT_OSC_LO]);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      OSC_MODE      <= 2'h3;
      OSC_RC_EN     <= 1'b0;
      OSC_XTAL_LOW  <= 1'b0;
      OSC_XTAL_MED  <= 1'b0;
      OSC_XTAL_HIGH <= 1'b1;
      BROWNOUT_EN   <= 1'b1;
      CODE_READ_EN  <= 1'b0;
      DEBUG_FULL    <= 1'b0;
      DEBUG_LIMITED <= 1'b0;
    end
    else if (CE)
    begin
      OSC_MODE      <= opt[`OBD_BIT_OSC_HI:`OBD_BIT_OSC_LO];
      OSC_RC_EN     <= next_osc[0];
      OSC_XTAL_LOW  <= next_osc[1];
      OSC_XTAL_MED  <= next_osc[2];
      OSC_XTAL_HIGH <= next_osc[3];
      BROWNOUT_EN   <= bo_ao || !STOP_MODE;
      CODE_READ_EN  <= opt_loaded && rd_open;
      DEBUG_FULL    <= dbg_sync && opt_loaded && rd_open;
      DEBUG_LIMITED <= dbg_sync && !(opt_loaded && rd_open);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic        wr;
  logic        mapped;
  logic        rd_ready;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [31:0] next_rdata;

  assign wr     = PSEL && PENABLE && PWRITE && PREADY;
  assign mapped = addr_is(PADDR, `OBD_ADDR_OPTION) || addr_is(PADDR, `OBD_ADDR_STATE)
               || addr_is(PADDR, `OBD_ADDR_CTRL) || addr_is(PADDR, `OBD_ADDR_IRQ_STAT)
               || addr_is(PADDR, `OBD_ADDR_IRQ_MASK);
  assign PREADY  = CE && (PWRITE || rd_ready);
  assign PSLVERR = PSEL && PENABLE && PREADY && !mapped;
  assign reload  = wr && addr_is(PADDR, `OBD_ADDR_CTRL) && PWDATA[`OBD_CTRL_RELOAD]
                && !ld_busy;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (addr_is(PADDR, `OBD_ADDR_OPTION))
      next_rdata = {23'h00_0000, opt_loaded, opt};
    else if (addr_is(PADDR, `OBD_ADDR_STATE))
      next_rdata = {23'h00_0000, ld_busy, DEBUG_FULL, CODE_READ_EN, BROWNOUT_EN,
                    OSC_MODE, WDT_SHORT_RST, WDT_INT_REQ, WDT_RUN};
    else if (addr_is(PADDR, `OBD_ADDR_CTRL))
      next_rdata = {31'h0000_0000, ld_busy};
    else if (addr_is(PADDR, `OBD_ADDR_IRQ_STAT))
      next_rdata = {29'h0000_0000, irq_stat};
    else if (addr_is(PADDR, `OBD_ADDR_IRQ_MASK))
      next_rdata = {29'h0000_0000, irq_mask};
  end

  // Read data is captured during the transfer so it stands from a flop
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PRDATA   <= 32'h0000_0000;
      rd_ready <= 1'b0;
    end
    else if (CE)
    begin
      rd_ready <= PSEL && !PWRITE && !(PENABLE && rd_ready);
      if (PSEL && !PWRITE)
        PRDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [2:0] events;
  logic [2:0] clr;

  assign events = {WDT_SHORT_RST, WDT_INT_REQ, opt_load};
  assign clr    = (wr && addr_is(PADDR, `OBD_ADDR_IRQ_STAT)) ? PWDATA[2:0] : 3'h0;

  // A new event in the clearing cycle keeps its bit set
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_stat <= 3'h0;
    else if (CE)
      irq_stat <= (irq_stat & ~clr) | events;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_mask <= `OBD_IRQ_MASK_RST;
    else if (CE && wr && addr_is(PADDR, `OBD_ADDR_IRQ_MASK))
      irq_mask <= PWDATA[2:0];
  end

  assign IRQ = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  property p_wdt_int;
    CE && WDT_TIMEOUT && WDT_RUN && !wdt_act |=> WDT_INT_REQ && !WDT_SHORT_RST;
  endproperty
  a_wdt_int: assert property (p_wdt_int) else $error("timeout did not raise interrupt");

  property p_wdt_rst;
    CE && WDT_TIMEOUT && WDT_RUN && wdt_act |=> WDT_SHORT_RST && !WDT_INT_REQ;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("timeout did not force reset");

  property p_wdt_always;
    CE && opt_loaded && !wdt_soft && !(STOP_MODE && WDT_STOP_PD) |=> WDT_RUN;
  endproperty
  a_wdt_always: assert property (p_wdt_always) else $error("always-on watchdog not running");

  property p_wdt_start;
    CE && opt_loaded && wdt_soft && WDT_START_INSTR && !SYS_RESET && !STOP_RECOVERY
      |=> WDT_RUN;
  endproperty
  a_wdt_start: assert property (p_wdt_start) else $error("start did not run watchdog");

  property p_wdt_hold;
    CE && wdt_soft && WDT_RUN && !SYS_RESET && !STOP_RECOVERY ##1 !CE [*2]
      |-> WDT_RUN;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog stopped on its own");

  property p_osc;
    CE ##1 1'b1 |-> OSC_MODE == $past(opt[5:4]) && $onehot({OSC_XTAL_HIGH, OSC_XTAL_MED,
                    OSC_XTAL_LOW, OSC_RC_EN});
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator drive wrong");

  property p_osc_hi;
    CE && opt[5:4] == 2'h3 |=> OSC_XTAL_HIGH && !OSC_RC_EN && !OSC_XTAL_MED;
  endproperty
  a_osc_hi: assert property (p_osc_hi) else $error("maximum drive not chosen");

  property p_bo;
    CE && STOP_MODE |=> BROWNOUT_EN == $past(bo_ao);
  endproperty
  a_bo: assert property (p_bo) else $error("brownout state in STOP wrong");

  property p_prot;
    CE && opt_loaded && !rd_open |=> !CODE_READ_EN && !DEBUG_FULL;
  endproperty
  a_prot: assert property (p_prot) else $error("protected code readable");

  property p_open;
    CE && opt_loaded && rd_open |=> CODE_READ_EN;
  endproperty
  a_open: assert property (p_open) else $error("unprotected code not readable");

  // Only checked while no fetch is under way, when the byte must hold
  property p_keep;
    CE && SYS_RESET && !ld_busy |=> $stable(opt) && opt_loaded;
  endproperty
  a_keep: assert property (p_keep) else $error("reset disturbed option byte");

  property p_irq_sticky;
    CE && |events |=> (irq_stat & $past(events)) == $past(events);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("event lost from status");

  c_wdt_int: cover property (CE && WDT_TIMEOUT && WDT_RUN && !wdt_act ##1 WDT_INT_REQ);
  c_wdt_rst: cover property (CE && WDT_TIMEOUT && WDT_RUN && wdt_act ##1 WDT_SHORT_RST);
  c_reload:  cover property (reload ##[1:20] opt_load);
  c_irq:     cover property (IRQ ##1 !IRQ);

endmodule : obd_option_decoder

`default_nettype wire

/* obd_option_decoder_tb.sv */
// Self-checking testbench for the option bit decoder top
`default_nettype none

module obd_option_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK, ARST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        FLASH_REQ, FLASH_ACK, SYS_RESET, STOP_MODE, STOP_RECOVERY, WDT_STOP_PD;
  logic [15:0] FLASH_ADDR;
  logic [7:0]  FLASH_RDATA;
  logic        WDT_START_INSTR, WDT_TIMEOUT, DEBUG_ATTACH, OPT_READY, WDT_RUN;
  logic        WDT_INT_REQ, WDT_SHORT_RST, OSC_RC_EN, OSC_XTAL_LOW, OSC_XTAL_MED;
  logic        OSC_XTAL_HIGH, BROWNOUT_EN, CODE_READ_EN, DEBUG_FULL, DEBUG_LIMITED;
  logic [1:0]  OSC_MODE;
  int          err_total = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          i;
  logic [7:0]  opt;
  logic [31:0] rd;
  logic        er;
  logic        dbg;

  obd_option_decoder dut
  (
    .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .FLASH_REQ(FLASH_REQ), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_RDATA(FLASH_RDATA), .FLASH_ACK(FLASH_ACK), .SYS_RESET(SYS_RESET),
    .STOP_MODE(STOP_MODE), .STOP_RECOVERY(STOP_RECOVERY), .WDT_STOP_PD(WDT_STOP_PD),
    .WDT_START_INSTR(WDT_START_INSTR), .WDT_TIMEOUT(WDT_TIMEOUT),
    .DEBUG_ATTACH(DEBUG_ATTACH), .OPT_READY(OPT_READY), .WDT_RUN(WDT_RUN),
    .WDT_INT_REQ(WDT_INT_REQ), .WDT_SHORT_RST(WDT_SHORT_RST), .OSC_MODE(OSC_MODE),
    .OSC_RC_EN(OSC_RC_EN), .OSC_XTAL_LOW(OSC_XTAL_LOW), .OSC_XTAL_MED(OSC_XTAL_MED),
    .OSC_XTAL_HIGH(OSC_XTAL_HIGH), .BROWNOUT_EN(BROWNOUT_EN), .CODE_READ_EN(CODE_READ_EN),
    .DEBUG_FULL(DEBUG_FULL), .DEBUG_LIMITED(DEBUG_LIMITED)
  );

  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expectations, comparison and closing report

  function automatic logic [3:0] exp_osc(input logic [1:0] m);
    return 4'h1 << m;
  endfunction : exp_osc

  function automatic logic [31:0] exp_irq(input logic [7:0] b);
    return b[7] ? 32'h00000004 : 32'h00000002;
  endfunction : exp_irq

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      err_total++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and stimulus tasks

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
    begin
      @(posedge CLK);
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : settle

  // Answer the pending program memory read with one byte
  task automatic load(input logic [7:0] b);
    @(posedge CLK);
    while (FLASH_REQ !== 1'b1)
    begin
      @(posedge CLK);
    end
    chk({16'h0000, FLASH_ADDR}, 32'h00000000);
    FLASH_RDATA <= b;
    FLASH_ACK <= 1'b1;
    @(posedge CLK);
    FLASH_ACK <= 1'b0;
    FLASH_RDATA <= ~b;
    settle(3);
    chk({30'h0, OPT_READY, FLASH_REQ}, 32'h00000002);
  endtask : load

  task automatic pulse(input int which);
    @(posedge CLK);
    case (which)
      0: SYS_RESET <= 1'b1;
      1: WDT_START_INSTR <= 1'b1;
      default: STOP_RECOVERY <= 1'b1;
    endcase
    @(posedge CLK);
    SYS_RESET <= 1'b0;
    WDT_START_INSTR <= 1'b0;
    STOP_RECOVERY <= 1'b0;
    settle(2);
  endtask : pulse

  // Time-out pulse; run says whether an output pulse is expected
  task automatic fire(input logic run, input logic [7:0] b);
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b1;
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
    #1;
    chk({30'h0, WDT_INT_REQ, WDT_SHORT_RST}, run ? {30'h0, ~b[7], b[7]} : 32'h0);
    settle(1);
    chk({30'h0, WDT_INT_REQ, WDT_SHORT_RST}, 32'h00000000);
  endtask : fire

  task automatic check_dec(input logic [7:0] b);
    chk({30'h0, OSC_MODE}, {30'h0, b[5:4]});
    chk({28'h0, OSC_XTAL_HIGH, OSC_XTAL_MED, OSC_XTAL_LOW, OSC_RC_EN},
        {28'h0, exp_osc(b[5:4])});
    chk({31'h0, CODE_READ_EN}, {31'h0, b[3]});
    chk({30'h0, DEBUG_FULL, DEBUG_LIMITED}, {30'h0, dbg & b[3], dbg & ~b[3]});
    chk({31'h0, BROWNOUT_EN}, 32'h00000001);
    apb(1'b0, 12'h000, 32'h00000000, rd, er);
    chk(rd, {23'h0, 1'b1, b});
    apb(1'b0, 12'h004, 32'h00000000, rd, er);
    chk(rd, {23'h0, 1'b0, dbg & b[3], b[3], 1'b1, b[5:4], 3'h1});
  endtask : check_dec

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence

  initial
  begin
    {ARST_N, PSEL, PENABLE, PWRITE, FLASH_ACK, SYS_RESET, STOP_MODE} = 7'h00;
    {STOP_RECOVERY, WDT_STOP_PD, WDT_START_INSTR, WDT_TIMEOUT, DEBUG_ATTACH} = 5'h00;
    CE = 1'b1;
    PADDR = 12'h000;
    PWDATA = 32'h00000000;
    FLASH_RDATA = 8'h00;
    dbg = 1'b0;
    rd = $urandom(32'h6705);
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    #1;
    chk({28'h0, OSC_XTAL_HIGH, OSC_XTAL_MED, OSC_XTAL_LOW, OSC_RC_EN}, 32'h00000008);
    chk({30'h0, OPT_READY, FLASH_REQ}, 32'h00000001);
    chk({31'h0, BROWNOUT_EN}, 32'h00000001);
    apb(1'b0, 12'h000, 32'h00000000, rd, er);
    chk(rd, 32'h000000FF);
    for (i = 0; i < 8; i++)
    begin
      opt = 8'($urandom);
      opt[5:4] = i[1:0];
      opt[6] = i[0] ^ i[2];
      opt[7] = i[2];
      dbg = i[1];
      @(posedge CLK);
      DEBUG_ATTACH <= dbg;
      if (i > 0)
        apb(1'b1, 12'h008, 32'h00000001, rd, er);
      load(opt);
      apb(1'b1, 12'h000, {24'h0, ~opt}, rd, er);
      apb(1'b1, 12'h014 + 12'(i * 8), 32'hFFFFFFFF, rd, er);
      apb(1'b0, 12'h014 + 12'(i * 8), 32'h00000000, rd, er);
      chk(rd, 32'h00000000);
      chk({31'h0, er}, 32'h00000001);
      check_dec(opt);
      @(posedge CLK);
      STOP_MODE <= 1'b1;
      settle(3);
      chk({31'h0, BROWNOUT_EN}, {31'h0, opt[2]});
      if (opt[6] == 1'b0)
      begin
        chk({31'h0, WDT_RUN}, 32'h00000001);
        @(posedge CLK);
        WDT_STOP_PD <= 1'b1;
        settle(3);
        chk({31'h0, WDT_RUN}, 32'h00000000);
        pulse(0);
        @(posedge CLK);
        STOP_MODE <= 1'b0;
        WDT_STOP_PD <= 1'b0;
        settle(3);
        chk({31'h0, WDT_RUN}, 32'h00000001);
      end
      else
      begin
        @(posedge CLK);
        STOP_MODE <= 1'b0;
        pulse(0);
        chk({31'h0, WDT_RUN}, 32'h00000000);
        fire(1'b0, opt);
        pulse(1);
        chk({31'h0, WDT_RUN}, 32'h00000001);
        pulse(2);
        chk({31'h0, WDT_RUN}, 32'h00000000);
        pulse(1);
      end
      apb(1'b0, 12'h000, 32'h00000000, rd, er);
      chk(rd, {23'h0, 1'b1, opt});
      apb(1'b0, 12'h00C, 32'h00000000, rd, er);
      chk(rd, 32'h00000001);
      apb(1'b1, 12'h00C, 32'h00000007, rd, er);
      fire(1'b1, opt);
      settle(2);
      apb(1'b0, 12'h00C, 32'h00000000, rd, er);
      chk(rd, exp_irq(opt));
      chk({31'h0, IRQ}, 32'h00000000);
      apb(1'b1, 12'h010, 32'h00000007, rd, er);
      settle(1);
      chk({31'h0, IRQ}, 32'h00000001);
      apb(1'b1, 12'h00C, exp_irq(opt), rd, er);
      settle(1);
      chk({31'h0, IRQ}, 32'h00000000);
      apb(1'b1, 12'h010, 32'h00000000, rd, er);
      // Recovery pulse while frozen must not stop the running watchdog
      @(posedge CLK);
      CE <= 1'b0;
      pulse(2);
      chk({31'h0, WDT_RUN}, 32'h00000001);
      CE <= 1'b1;
    end
    print_verdict();
  end

endmodule : obd_option_decoder_tb

`default_nettype wire

/* obd_pkg.sv */
// Types shared by the option bit decoder modules
`default_nettype none

package obd_pkg;

  typedef enum logic [1:0]
  {
    OBD_OSC_RC       = 2'h0,
    OBD_OSC_XTAL_LOW = 2'h1,
    OBD_OSC_XTAL_MED = 2'h2,
    OBD_OSC_XTAL_HI  = 2'h3
  } obd_osc_mode_t;

  typedef enum logic [1:0] {LD_READ, LD_IDLE} obd_ld_state_t;

endpackage : obd_pkg

`default_nettype wire

/* obd_sync.sv */
// Two-stage synchroniser for a level arriving from outside the clock domain
`default_nettype none

module obd_sync
(
  input  wire logic clk,     // System clock
  input  wire logic arst_n,  // Asynchronous reset, active low
  input  wire logic ce,      // Clock enable
  input  wire logic d,       // Asynchronous input
  output var  logic q        // Synchronised level
);

  logic stage1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= 1'b0;
      q      <= 1'b0;
    end
    else if (ce)
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : obd_sync

`default_nettype wire
